/* File: inc/voltage_reference_control_regs.vh */
`ifndef VOLTAGE_REFERENCE_CONTROL_REGS_VH
`define VOLTAGE_REFERENCE_CONTROL_REGS_VH

// register byte addresses
`define REF_CONTROL_ADDR     12'h000
`define REF_IRQ_STATUS_ADDR  12'h004
`define REF_IRQ_MASK_ADDR    12'h008

// reference_control fields
`define REF_ENABLE_BIT       7
`define REF_READY_BIT        6
`define REF_RSVD_HI          5
`define REF_RSVD_LO          4
`define REF_CMP_GAIN_HI      3
`define REF_CMP_GAIN_LO      2
`define REF_ADC_GAIN_HI      1
`define REF_ADC_GAIN_LO      0
`define REF_CONTROL_RESET    8'h00

// gain select encodings
`define REF_GAIN_OFF         2'h0
`define REF_GAIN_1X          2'h1
`define REF_GAIN_2X          2'h2
`define REF_GAIN_4X          2'h3

// interrupt status/mask fields
`define REF_IRQ_READY_BIT    0
`define REF_IRQ_LOST_BIT     1
`define REF_IRQ_RESET        2'h0

// stabilisation time
`define REF_SETTLE_TIME_NS   25000
`define REF_CLK_PERIOD_NS    10
`define REF_SETTLE_CYCLES    ((`REF_SETTLE_TIME_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)

`endif

/* File: src/voltage_reference_control.v */
// Function
// - enable bit seven switches reference on
// - ready raised only after stabilisation completes
// - ready read-only, zero while off/settling
// - reserved bits five, four read zero
// - comparator/DAC gain: off, 1x, 2x, 4x
// - ADC gain: off, 1x, 2x, 4x
// - two independent gain paths configured separately
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "voltage_reference_control_regs.vh"

module voltage_reference_control #(
  parameter integer SETTLE_CYCLES = `REF_SETTLE_CYCLES
) (
  input  wire        core_clk_in,        // system clock, 100 MHz
  input  wire        rst_n_in,           // synchronous reset, active low
  input  wire        psel_in,            // apb select
  input  wire        penable_in,         // apb access phase
  input  wire        pwrite_in,          // apb direction, 1 = write
  input  wire [11:0] paddr_in,           // apb byte address
  input  wire [31:0] pwdata_in,          // apb write data
  output wire        pready_out,         // apb ready
  output reg  [31:0] prdata_out,         // apb read data
  output wire        pslverr_out,        // apb error, unmapped address
  output reg         reference_enable_out, // analog reference enable
  output reg         reference_ready_out,  // reference usable
  output reg  [2:0]  adc_gain_out,       // adc path one-hot {4x,2x,1x}, zero = off
  output reg  [2:0]  cmp_dac_gain_out,   // comparator/dac/sensing path one-hot, zero = off
  output wire        irq_out             // level interrupt
);

  localparam [2:0] ST_OFF    = 3'b001;
  localparam [2:0] ST_SETTLE = 3'b010;
  localparam [2:0] ST_READY  = 3'b100;

  reg [2:0]  state_reg;
  reg [2:0]  state_next;
  reg [31:0] settle_cnt_reg;
  reg [31:0] settle_cnt_next;
  reg        reference_enable_reg;
  reg [1:0]  adc_gain_select_reg;
  reg [1:0]  comparator_dac_gain_select_reg;
  reg [1:0]  irq_status_reg;
  reg [1:0]  irq_mask_reg;

  wire access_w = psel_in & penable_in;
  wire wr_w     = access_w & pwrite_in;
  wire hit_ctrl = (paddr_in == `REF_CONTROL_ADDR);
  wire hit_stat = (paddr_in == `REF_IRQ_STATUS_ADDR);
  wire hit_mask = (paddr_in == `REF_IRQ_MASK_ADDR);
  wire ready_w  = (state_reg == ST_READY);
  wire ready_evt_w;
  wire lost_evt_w;

  // decodes a two-bit gain field into amplifier select lines
  function [2:0] gain_decode;
    input [1:0] sel;
    begin
      case (sel)
        `REF_GAIN_1X: gain_decode = 3'h1;
        `REF_GAIN_2X: gain_decode = 3'h2;
        `REF_GAIN_4X: gain_decode = 3'h4;
        default:      gain_decode = 3'h0;
      endcase
    end
  endfunction

  assign pready_out  = 1'b1;
  assign pslverr_out = access_w & ~(hit_ctrl | hit_stat | hit_mask);

  // control register; reserved bits are dropped on write so they can never read back
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      reference_enable_reg           <= 1'b0;
      adc_gain_select_reg            <= `REF_GAIN_OFF;
      comparator_dac_gain_select_reg <= `REF_GAIN_OFF;
    end else if (wr_w && hit_ctrl) begin
      reference_enable_reg           <= pwdata_in[`REF_ENABLE_BIT];
      comparator_dac_gain_select_reg <= pwdata_in[`REF_CMP_GAIN_HI:`REF_CMP_GAIN_LO];
      adc_gain_select_reg            <= pwdata_in[`REF_ADC_GAIN_HI:`REF_ADC_GAIN_LO];
    end
  end

  // settle sequencer; leaving enable at any point restarts the wait from zero
  always @* begin
    state_next      = state_reg;
    settle_cnt_next = settle_cnt_reg;
    case (state_reg)
      ST_OFF: begin
        settle_cnt_next = 32'h0000_0000;
        if (reference_enable_reg) begin
          state_next = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (!reference_enable_reg) begin
          state_next      = ST_OFF;
          settle_cnt_next = 32'h0000_0000;
        end else if (settle_cnt_reg >= SETTLE_CYCLES - 1) begin
          state_next = ST_READY;
        end else begin
          settle_cnt_next = settle_cnt_reg + 32'h0000_0001;
        end
      end
      ST_READY: begin
        if (!reference_enable_reg) begin
          state_next      = ST_OFF;
          settle_cnt_next = 32'h0000_0000;
        end
      end
      default: begin
        state_next      = ST_OFF;
        settle_cnt_next = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      state_reg      <= ST_OFF;
      settle_cnt_reg <= 32'h0000_0000;
    end else begin
      state_reg      <= state_next;
      settle_cnt_reg <= settle_cnt_next;
    end
  end

  assign ready_evt_w = (state_reg == ST_SETTLE) && (state_next == ST_READY);
  assign lost_evt_w  = ready_w && (state_next == ST_OFF);

  // sticky status, write one to clear; a new event in the clearing cycle wins
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      irq_status_reg <= `REF_IRQ_RESET;
      irq_mask_reg   <= `REF_IRQ_RESET;
    end else begin
      irq_status_reg <= (irq_status_reg & ~((wr_w && hit_stat) ? pwdata_in[1:0] : 2'h0))
                        | {lost_evt_w, ready_evt_w};
      if (wr_w && hit_mask) begin
        irq_mask_reg <= pwdata_in[1:0];
      end
    end
  end

  assign irq_out = |(irq_status_reg & irq_mask_reg);

  // analog-facing outputs from flops; gains stay off while the reference is off
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      reference_enable_out <= 1'b0;
      reference_ready_out  <= 1'b0;
      adc_gain_out         <= 3'h0;
      cmp_dac_gain_out     <= 3'h0;
    end else begin
      reference_enable_out <= reference_enable_reg;
      reference_ready_out  <= ready_w;
      adc_gain_out         <= reference_enable_reg ? gain_decode(adc_gain_select_reg) : 3'h0;
      cmp_dac_gain_out     <= reference_enable_reg ? gain_decode(comparator_dac_gain_select_reg) : 3'h0;
    end
  end

  // read mux, registered so data is valid at the access edge after setup
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (psel_in && !penable_in && !pwrite_in) begin
      if (paddr_in == `REF_CONTROL_ADDR) begin
        prdata_out <= {24'h00_0000, reference_enable_reg, ready_w, 2'h0,
                       comparator_dac_gain_select_reg, adc_gain_select_reg};
      end else if (paddr_in == `REF_IRQ_STATUS_ADDR) begin
        prdata_out <= {30'h0000_0000, irq_status_reg};
      end else if (paddr_in == `REF_IRQ_MASK_ADDR) begin
        prdata_out <= {30'h0000_0000, irq_mask_reg};
      end else begin
        prdata_out <= 32'h0000_0000;
      end
    end
  end

endmodule
`default_nettype wire

/* File: dv/voltage_reference_control_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module ref_ctrl_monitor #(
  parameter integer SETTLE_CYCLES = 4
) (
  input wire        core_clk_in,          // clock
  input wire        rst_n_in,             // reset
  input wire        psel_in,              // select
  input wire        penable_in,           // access
  input wire        pwrite_in,            // write
  input wire [11:0] paddr_in,             // address
  input wire [31:0] pwdata_in,            // wdata
  input wire [31:0] prdata_out,           // rdata
  input wire        reference_enable_out, // enable
  input wire        reference_ready_out,  // ready
  input wire [2:0]  adc_gain_out,         // adc gain
  input wire [2:0]  cmp_dac_gain_out      // cmp gain
);
  wire       acc = psel_in && penable_in && paddr_in == 12'h000;
  reg  [7:0] last_reg;
  always @(posedge core_clk_in) if (acc && pwrite_in) last_reg <= pwdata_in[7:0];
  function [2:0] oh(input [1:0] g);
    oh = (g == 2'h0) ? 3'h0 : 3'h1 << (g - 2'h1);
  endfunction
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_en; acc && pwrite_in |-> ##[1:2] reference_enable_out == last_reg[7]; endproperty
  a_en: assert property (p_en) else $error("enable mismatch");
  property p_gain; acc && pwrite_in && pwdata_in[7]
    |-> ##[1:3] adc_gain_out == oh(last_reg[1:0]) && cmp_dac_gain_out == oh(last_reg[3:2]); endproperty
  a_gain: assert property (p_gain) else $error("gain mismatch");
  property p_hot; $onehot0(adc_gain_out) && $onehot0(cmp_dac_gain_out); endproperty
  a_hot: assert property (p_hot) else $error("gain not one-hot");
  property p_off; !reference_enable_out && !$past(reference_enable_out)
    |-> adc_gain_out == 3'h0 && cmp_dac_gain_out == 3'h0; endproperty
  a_off: assert property (p_off) else $error("gain on while off");
  property p_set; $rose(reference_ready_out) |-> $past(reference_enable_out, SETTLE_CYCLES); endproperty
  a_set: assert property (p_set) else $error("ready too early");
  property p_drop; $fell(reference_enable_out) |-> ##[0:2] !reference_ready_out; endproperty
  a_drop: assert property (p_drop) else $error("ready kept");
  property p_rsv; acc && !pwrite_in |-> prdata_out[31:8] == 24'h0 && prdata_out[5:4] == 2'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_rdy; acc && !pwrite_in |-> prdata_out[6] == reference_ready_out; endproperty
  a_rdy: assert property (p_rdy) else $error("ready readback");
endmodule
bind voltage_reference_control ref_ctrl_monitor #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_mon (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
  .reference_enable_out(reference_enable_out), .reference_ready_out(reference_ready_out),
  .adc_gain_out(adc_gain_out), .cmp_dac_gain_out(cmp_dac_gain_out));
`default_nettype wire

/* File: dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "voltage_reference_control_regs.vh"
module testbench;
  logic        core_clk_in, rst_n_in, psel_in, penable_in, pwrite_in, err;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd;
  logic        pready_out, pslverr_out, reference_enable_out, reference_ready_out, irq_out;
  logic [2:0]  adc_gain_out, cmp_dac_gain_out;
  int          num_errors = 0, checks_done = 0, cyc = 0, g;
  voltage_reference_control #(.SETTLE_CYCLES(4)) u_voltage_reference_control (.core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pready_out(pready_out), .prdata_out(prdata_out),
    .pslverr_out(pslverr_out), .reference_enable_out(reference_enable_out),
    .reference_ready_out(reference_ready_out), .adc_gain_out(adc_gain_out),
    .cmp_dac_gain_out(cmp_dac_gain_out), .irq_out(irq_out));
  initial begin
    core_clk_in = 0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  task print_verdict;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      num_errors = num_errors + 1;
      print_verdict();
    end
  end
  function logic [2:0] oh(input logic [1:0] v);
    oh = (v == 2'h0) ? 3'h0 : 3'h1 << (v - 2'h1);
  endfunction
  task chk(input logic [35:0] got, input logic [35:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // one setup cycle, then access held until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel_in <= 1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge core_clk_in) penable_in <= 1;
    do @(posedge core_clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 0;
    penable_in <= 0;
    @(posedge core_clk_in);
  endtask
  initial begin
    {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in, rst_n_in} = 0;
    repeat (4) @(posedge core_clk_in);
    rst_n_in <= 1;
    @(posedge core_clk_in);
    apb(0, `REF_CONTROL_ADDR, 0);
    chk(rd, 36'h0);
    apb(1, `REF_IRQ_MASK_ADDR, 32'h1);
    apb(1, `REF_CONTROL_ADDR, 32'hC9);
    apb(0, `REF_CONTROL_ADDR, 0);
    chk(rd, 36'h89);
    chk({adc_gain_out, cmp_dac_gain_out}, {oh(2'h1), oh(2'h2)});
    for (int i = 0; i < 20 && reference_ready_out !== 1'b1; i++) @(posedge core_clk_in);
    apb(0, `REF_CONTROL_ADDR, 0);
    chk({irq_out, rd}, 36'h1000000C9);
    apb(1, `REF_IRQ_STATUS_ADDR, 32'h1);
    chk(irq_out, 36'h0);
    $display("test settle done");
    for (g = 0; g < 4; g++) begin
      apb(1, `REF_CONTROL_ADDR, 32'h80 | (g << 2) | (3 - g));
      @(posedge core_clk_in);
      chk({adc_gain_out, cmp_dac_gain_out}, {oh(3 - g), oh(g)});
    end
    $display("test gains done");
    apb(1, `REF_CONTROL_ADDR, 0);
    repeat (2) @(posedge core_clk_in);
    chk({reference_enable_out, reference_ready_out, adc_gain_out, cmp_dac_gain_out}, 36'h0);
    apb(0, 12'h010, 0);
    chk({err, rd}, 36'h100000000);
    apb(0, `REF_IRQ_STATUS_ADDR, 0);
    chk({irq_out, rd}, 36'h2);
    $display("test off done");
    print_verdict();
  end
endmodule
`default_nettype wire
